// ===== design/node_cfg.sv
// Node configuration: object entries, position value and bit rate start-up
`timescale 1ns/1ps
module node_cfg (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset, power-up
    input wire logic nmt_reset, // Network reset pulse
    input wire logic can_rx, // Bus receive pin
    input wire logic [15:0] od_index, // Object index
    input wire logic [7:0] od_sub, // Object sub-index
    input wire logic od_wr, // Write strobe
    input wire logic od_rd, // Read strobe
    input wire logic [63:0] od_wdata, // Write data
    output logic [63:0] od_rdata, // Read data
    output logic od_ack, // Access done
    output logic od_abort, // Access refused
    input wire logic [15:0] event_timer_ms, // Transmit event timer
    input wire logic [15:0] single_raw, // Single-turn count
    input wire logic [30:0] turns_raw, // Multi-turn count
    input wire logic [31:0] steps_per_rev, // Programmed steps per turn
    input wire logic [31:0] preset_value, // Programmed preset
    input wire logic preset_load, // Apply preset now
    input wire logic nvm_done, // Storage finished
    output logic nvm_save, // Pulse: store all entries
    output logic dev_reset, // Pulse: reset the device
    output logic [7:0] node_id, // Effective node identifier
    output logic [7:0] rate_active, // Rate code in use
    output logic term_en, // Termination on
    output logic listen_only, // Transmitter held off
    output logic bootup_send, // Pulse: send boot-up message
    output logic preop, // In pre-operational state
    output logic led_red, // Red indicator
    output logic led_green // Green indicator
);
    import node_cfg_pkg::*;

    // ------------------------------------------------------------------
    // Stored entries
    // ------------------------------------------------------------------
    logic [7:0] node_base_q; // Stored node number
    logic [7:0] rate_code_q; // Stored bit rate code
    logic [7:0] term_q; // Termination entry
    logic [7:0] ar_en_q; // Detection enable
    logic [31:0] ar_tmo_q; // Detection timeout ms
    logic [63:0] offset_q; // Preset offset
    logic [63:0] pos_q; // Wide position, registered
    node_state_e state_q; // Start-up state
    node_state_e state_d; // Next state
    logic [31:0] ms_q; // Ms since reset
    logic [7:0] led_ms_q; // Indicator swap counter
    logic led_phase_q; // Which indicator lit
    logic saving_q; // Waiting for storage
    logic rx_m_q; // First sync stage
    logic rx_s_q; // Second sync stage
    logic tick_w; // Millisecond tick
    logic restart_w; // Power-up or network reset
    logic timed_out_w; // Detection window over

    rate_if rif ();

    // ------------------------------------------------------------------
    // Pin synchroniser; first stage read by second only
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        rx_m_q <= can_rx;
        rx_s_q <= rx_m_q;
    end

    assign restart_w = rst || nmt_reset;

    ms_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk_sys(clk_sys),
        .rst(rst),
        .restart(nmt_reset),
        .tick(tick_w)
    );

    rate_detect u_det (
        .clk_sys(clk_sys),
        .rst(rst),
        .rx_s(rx_s_q),
        .rif(rif)
    );

    // ------------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------------
    logic hit_period_w; // Cyclic period entry
    logic hit_save_w; // Save entry
    logic hit_pos_w; // Position entry
    logic hit_node_w; // Node base entry
    logic hit_rate_w; // Rate code entry
    logic hit_term_w; // Termination entry
    logic hit_arc_w; // Auto rate count
    logic hit_are_w; // Auto rate enable
    logic hit_art_w; // Auto rate timeout
    logic sub0_w; // Sub-index zero
    logic known_w; // Any mapped entry
    logic ro_w; // Read-only entry
    logic wr_ok_w; // Write accepted
    logic rd_ok_w; // Read accepted
    logic save_key_w; // Access code matches
    logic [63:0] rd_w; // Read mux

    assign sub0_w = od_sub == SUB_COUNT;
    assign hit_period_w = od_index == IDX_CYCLIC_PERIOD && sub0_w;
    assign hit_save_w = od_index == IDX_SAVE_RESET && sub0_w;
    assign hit_pos_w = od_index == IDX_WIDE_POS && sub0_w;
    assign hit_node_w = od_index == IDX_NODE_BASE && sub0_w;
    assign hit_rate_w = od_index == IDX_BIT_RATE && sub0_w;
    assign hit_term_w = od_index == IDX_TERM && sub0_w;
    assign hit_arc_w = od_index == IDX_AUTORATE && sub0_w;
    assign hit_are_w = od_index == IDX_AUTORATE && od_sub == SUB_ENABLE;
    assign hit_art_w = od_index == IDX_AUTORATE && od_sub == SUB_TIMEOUT;
    assign known_w = hit_period_w | hit_save_w | hit_pos_w | hit_node_w | hit_rate_w
                     | hit_term_w | hit_arc_w | hit_are_w | hit_art_w;
    assign ro_w = hit_period_w | hit_pos_w | hit_arc_w;
    // Enable takes only 0 or 1, rate code only table codes
    assign wr_ok_w = od_wr && known_w && !ro_w && !saving_q
                     && !(hit_are_w && od_wdata[7:0] > AUTORATE_EN_RST)
                     && !(hit_rate_w && od_wdata[7:0] > RATE_CODE_MAX);
    assign rd_ok_w = od_rd && known_w && !hit_save_w;
    assign save_key_w = od_wdata[31:0] == SAVE_ACCESS_CODE;

    // Read data; reserved upper bits read as zero
    assign rd_w = hit_period_w ? {48'h0, event_timer_ms} :
                  hit_pos_w ? pos_q :
                  hit_node_w ? {56'h0, node_base_q} :
                  hit_rate_w ? {56'h0, rate_code_q} :
                  hit_term_w ? {56'h0, term_q} :
                  hit_arc_w ? {56'h0, AUTORATE_COUNT} :
                  hit_are_w ? {56'h0, ar_en_q} :
                  hit_art_w ? {32'h0, ar_tmo_q} : 64'h0;

    // ------------------------------------------------------------------
    // Access answer, one cycle after the strobe
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            od_ack <= 1'b0;
            od_abort <= 1'b0;
            od_rdata <= '0;
        end else begin
            od_ack <= od_wr || od_rd;
            od_abort <= (od_wr && !wr_ok_w) || (od_rd && !rd_ok_w);
            od_rdata <= rd_ok_w ? rd_w : 64'h0;
        end
    end

    // ------------------------------------------------------------------
    // Stored entries; a detected rate wins over a master write
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            node_base_q <= NODE_BASE_RST;
            rate_code_q <= RATE_CODE_RST;
            term_q <= TERM_RST;
            ar_en_q <= AUTORATE_EN_RST;
            ar_tmo_q <= AUTORATE_TMO_RST;
        end else begin
            if (wr_ok_w && hit_node_w) begin
                node_base_q <= od_wdata[7:0];
            end
            if (state_q == ST_DETECT && rif.found) begin
                rate_code_q <= rif.code;
            end else if (wr_ok_w && hit_rate_w) begin
                rate_code_q <= od_wdata[7:0];
            end
            if (wr_ok_w && hit_term_w) begin
                term_q <= od_wdata[7:0];
            end
            if (wr_ok_w && hit_are_w) begin
                ar_en_q <= od_wdata[7:0];
            end
            if (wr_ok_w && hit_art_w) begin
                ar_tmo_q <= od_wdata[31:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Save then reset; storage must finish before the reset goes out
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            saving_q <= 1'b0;
            nvm_save <= 1'b0;
            dev_reset <= 1'b0;
        end else begin
            nvm_save <= wr_ok_w && hit_save_w && save_key_w;
            dev_reset <= saving_q && nvm_done;
            if (wr_ok_w && hit_save_w && save_key_w) begin
                saving_q <= 1'b1;
            end else if (nvm_done) begin
                saving_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Wide position: scaled by steps per turn, no total-range wrap
    // ------------------------------------------------------------------
    logic [63:0] turns_scaled_w; // Whole turns in steps
    logic [47:0] frac_scaled_w; // Single-turn part in steps
    logic [63:0] pos_raw_w; // Unwrapped scaled position
    assign turns_scaled_w = 64'(turns_raw) * 64'(steps_per_rev);
    assign frac_scaled_w = 48'(single_raw) * 48'(steps_per_rev);
    assign pos_raw_w = turns_scaled_w + {32'h0, frac_scaled_w[47:16]};

    // Preset is 32-bit wide by port, so always representable
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            offset_q <= '0;
            pos_q <= '0;
        end else begin
            if (preset_load) begin
                offset_q <= {32'h0, preset_value} - pos_raw_w;
            end
            pos_q <= pos_raw_w + offset_q;
        end
    end

    // ------------------------------------------------------------------
    // Timeout counted from power-up or network reset
    // ------------------------------------------------------------------
    assign timed_out_w = ar_tmo_q != 32'h0 && ms_q >= ar_tmo_q;

    always_ff @(posedge clk_sys) begin
        if (restart_w) begin
            ms_q <= '0;
        end else if (tick_w && ms_q != 32'hffffffff) begin
            ms_q <= ms_q + 32'h1;
        end
    end

    // ------------------------------------------------------------------
    // Start-up sequence
    // ------------------------------------------------------------------
    // Bad frames need no action here: the detector rearms itself
    assign rif.run = state_q == ST_DETECT && !restart_w;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_DETECT: begin
                if (rif.found || timed_out_w || ar_en_q == 8'h00) begin
                    state_d = ST_BOOTUP;
                end
            end
            ST_BOOTUP: state_d = ST_PREOP;
            ST_PREOP: state_d = ST_PREOP;
            default: state_d = ST_BOOTUP;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= ST_DETECT;
        end else if (nmt_reset) begin
            state_q <= ST_DETECT;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs from flip-flops
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            node_id <= NODE_BASE_RST + NODE_ID_STEP;
            rate_active <= RATE_CODE_RST;
            term_en <= 1'b0;
            listen_only <= 1'b1;
            bootup_send <= 1'b0;
            preop <= 1'b0;
        end else begin
            node_id <= node_base_q + NODE_ID_STEP;
            rate_active <= rate_code_q;
            term_en <= term_q == TERM_ON;
            // Network reset silences the transmitter at once
            listen_only <= nmt_reset || state_d == ST_DETECT;
            bootup_send <= state_q == ST_BOOTUP;
            preop <= state_q == ST_PREOP;
        end
    end

    // ------------------------------------------------------------------
    // Indicators swap every LED_FLASH_MS while detecting
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            led_ms_q <= '0;
            led_phase_q <= 1'b0;
            led_red <= 1'b0;
            led_green <= 1'b0;
        end else begin
            if (tick_w) begin
                if (led_ms_q == 8'(LED_FLASH_MS - 1)) begin
                    led_ms_q <= '0;
                    led_phase_q <= !led_phase_q;
                end else begin
                    led_ms_q <= led_ms_q + 8'h01;
                end
            end
            led_red <= state_q == ST_DETECT && led_phase_q;
            led_green <= state_q == ST_DETECT && !led_phase_q;
        end
    end
endmodule

// ===== shared/node_cfg_pkg.sv
// Package of object addresses, reset values and timing constants for the node configuration
package node_cfg_pkg;
    // ------------------------------------------------------------------
    // Object dictionary addresses
    // ------------------------------------------------------------------
    localparam logic [15:0] IDX_CYCLIC_PERIOD = 16'h2200; // Cyclic event period
    localparam logic [15:0] IDX_SAVE_RESET = 16'h2300; // Save all then reset
    localparam logic [15:0] IDX_WIDE_POS = 16'h2600; // Wide position value
    localparam logic [15:0] IDX_NODE_BASE = 16'h3000; // Node identifier base
    localparam logic [15:0] IDX_BIT_RATE = 16'h3001; // Bit rate code
    localparam logic [15:0] IDX_TERM = 16'h3002; // Termination switch
    localparam logic [15:0] IDX_AUTORATE = 16'h3003; // Auto rate object
    localparam logic [7:0] SUB_COUNT = 8'h00; // Entry count sub-index
    localparam logic [7:0] SUB_ENABLE = 8'h01; // Enable sub-index
    localparam logic [7:0] SUB_TIMEOUT = 8'h02; // Timeout sub-index
    // ------------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------------
    localparam logic [31:0] SAVE_ACCESS_CODE = 32'h55aaaa55; // Save key
    localparam logic [7:0] NODE_BASE_RST = 8'h1f; // Stored node number
    localparam logic [7:0] NODE_ID_STEP = 8'h01; // Added to stored node number
    localparam logic [7:0] RATE_CODE_RST = 8'h03; // 125 kbit/s, unconfigured unit
    localparam logic [7:0] RATE_CODE_MAX = 8'h07; // Highest valid code
    localparam logic [7:0] TERM_RST = 8'h00; // Termination off
    localparam logic [7:0] TERM_ON = 8'h01; // Value that switches it on
    localparam logic [7:0] AUTORATE_COUNT = 8'h02; // Number of sub-indices
    localparam logic [7:0] AUTORATE_EN_RST = 8'h01; // Detection enabled
    localparam logic [31:0] AUTORATE_TMO_RST = 32'h0002bf20; // Timeout in ms
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 125_000_000; // System clock rate
    localparam int TICK_MS = 1; // Tick period in ms
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS; // Cycles per tick
    localparam int LED_FLASH_MS = 100; // Indicator swap period in ms
    localparam int MIN_FRAME_EDGES = 16; // Edges needed for a valid frame
    localparam int IDLE_BITS = 11; // Recessive bits ending a frame
    // Cycles per bit for each rate code 0..7
    localparam logic [15:0] BIT_CYCLES [8] = '{16'h186a, 16'h09c4, 16'h04e2, 16'h03e8,
                                               16'h01f4, 16'h00fa, 16'h009c, 16'h007d};
    // Node start-up states
    typedef enum logic [1:0] {
        ST_DETECT = 2'b00,
        ST_BOOTUP = 2'b01,
        ST_PREOP = 2'b10
    } node_state_e;
endpackage

// ===== shared/rate_if.sv
// Interface between the node controller and the bit rate detector
`timescale 1ns/1ps
interface rate_if;
    logic run; // Detector allowed to measure
    logic found; // Pulse: valid frame measured
    logic bad; // Pulse: invalid frame seen
    logic [7:0] code; // Detected rate code
    modport ctrl (output run, input found, input bad, input code);
    modport det (input run, output found, output bad, output code);
endinterface

// ===== design/ms_tick.sv
// Millisecond tick generator from the system clock
`timescale 1ns/1ps
module ms_tick #(
    parameter int CYCLES = node_cfg_pkg::TICK_CYCLES // Cycles per tick
) (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic restart, // Restart the count
    output logic tick // One-cycle pulse each period
);
    import node_cfg_pkg::*;
    localparam int W = $clog2(CYCLES);
    logic [W-1:0] cnt_q; // Cycle counter
    logic last_w; // Final cycle of period
    assign last_w = (cnt_q == W'(CYCLES - 1));
    // ------------------------------------------------------------------
    // Counter; restart keeps timeout aligned to the reset moment
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst || restart || last_w) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + W'(1);
        end
        tick <= !rst && !restart && last_w;
    end
endmodule

// ===== design/rate_detect.sv
// Bit rate detector: measures the shortest bit on the line over one frame
`timescale 1ns/1ps
module rate_detect (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic rx_s, // Synchronised receive line
    rate_if.det rif // Link to controller
);
    import node_cfg_pkg::*;
    logic rx_d_q; // Previous line level
    logic [15:0] run_q; // Cycles since last edge
    logic [15:0] min_q; // Shortest pulse this frame
    logic [7:0] edges_q; // Edges this frame
    logic edge_w; // Line changed
    logic idle_w; // Frame has ended
    logic [7:0] code_w; // Matched code
    logic hit_w; // Shortest pulse matches a rate
    assign edge_w = rx_s != rx_d_q;
    assign idle_w = rx_s && edges_q != 8'h00 && min_q != 16'hffff
                    && (run_q == 16'hffff || 32'(run_q) > 32'(min_q) * 32'(IDLE_BITS));
    // ------------------------------------------------------------------
    // Match within one eighth of a bit; only table rates are accepted
    // ------------------------------------------------------------------
    always_comb begin
        code_w = 8'h00;
        hit_w = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (min_q >= BIT_CYCLES[i] - (BIT_CYCLES[i] >> 3)
                && min_q <= BIT_CYCLES[i] + (BIT_CYCLES[i] >> 3)) begin
                code_w = 8'(i);
                hit_w = 1'b1;
            end
        end
    end
    // ------------------------------------------------------------------
    // Pulse measurement; an invalid frame simply rearms the search
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        rx_d_q <= rx_s;
        rif.found <= 1'b0;
        rif.bad <= 1'b0;
        if (rst || !rif.run || idle_w) begin
            run_q <= '0;
            min_q <= 16'hffff;
            edges_q <= '0;
            if (!rst && rif.run && idle_w) begin
                rif.found <= hit_w && edges_q >= 8'(MIN_FRAME_EDGES);
                rif.bad <= !(hit_w && edges_q >= 8'(MIN_FRAME_EDGES));
                rif.code <= code_w;
            end
        end else if (edge_w) begin
            run_q <= '0;
            if (edges_q != 8'h00 && run_q < min_q) begin
                min_q <= run_q; // First edge is the frame start
            end
            if (edges_q != 8'hff) begin
                edges_q <= edges_q + 8'h01;
            end
        end else if (run_q != 16'hffff) begin
            run_q <= run_q + 16'h0001;
        end
        if (rst) begin
            rif.code <= '0;
        end
    end
endmodule

// ===== tb/node_cfg_chk.sv
// Concurrent checker for the node configuration block ports
`timescale 1ns/1ps
module node_cfg_chk (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic [15:0] od_index, // Object index
    input wire logic [7:0] od_sub, // Sub-index
    input wire logic od_wr, // Write strobe
    input wire logic od_rd, // Read strobe
    input wire logic [63:0] od_wdata, // Write data
    input wire logic od_ack, // Access done
    input wire logic od_abort, // Access refused
    input wire logic nvm_done, // Storage finished
    input wire logic nvm_save, // Store request
    input wire logic dev_reset, // Device reset pulse
    input wire logic [7:0] node_id, // Effective identifier
    input wire logic [7:0] rate_active, // Rate in use
    input wire logic term_en, // Termination on
    input wire logic listen_only, // Transmitter held off
    input wire logic bootup_send, // Boot-up pulse
    input wire logic preop // Pre-operational
);
    import node_cfg_pkg::*;
    // ------------------------------------------------------------
    // Assertions, all in the system clock domain
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Boot-up pulse comes first, pre-operational follows it
    sequence s_boot;
        bootup_send ##1 preop;
    endsequence
    a_ack_after_req: assert property ((od_wr || od_rd) |=> od_ack)
        else $error("access not acknowledged");
    a_node_id_step: assert property (od_wr && od_index == IDX_NODE_BASE ##1 !od_abort
        |=> node_id == $past(od_wdata[7:0], 2) + 8'h01) else $error("node id not base plus one");
    a_term_on_write: assert property (od_wr && od_index == IDX_TERM && od_wdata[7:0] == 8'h01
        ##1 !od_abort |=> term_en) else $error("termination not switched on");
    a_rate_write: assert property (preop && od_wr && od_index == IDX_BIT_RATE ##1 !od_abort
        |=> rate_active == $past(od_wdata[7:0], 2)) else $error("rate code not taken");
    a_rate_refused: assert property (od_wr && od_index == IDX_BIT_RATE
        && od_wdata[7:0] > 8'h07 |=> od_abort) else $error("bad rate code accepted");
    a_save_request: assert property (od_wr && od_index == IDX_SAVE_RESET
        && od_wdata[31:0] == 32'h55aaaa55 |=> nvm_save || od_abort) else $error("no save");
    a_reset_after_store: assert property (dev_reset |-> $past(nvm_done))
        else $error("reset before store done");
    a_boot_then_preop: assert property ($fell(listen_only) |=> s_boot)
        else $error("boot-up order wrong");
endmodule
bind node_cfg node_cfg_chk u_chk (.clk_sys, .rst, .od_index, .od_sub, .od_wr, .od_rd,
    .od_wdata, .od_ack, .od_abort, .nvm_done, .nvm_save, .dev_reset, .node_id, .rate_active,
    .term_en, .listen_only, .bootup_send, .preop);

// ===== tb/can_master_model.sv
// Far-side master model that puts test frames on the receive line
`timescale 1ns/1ps
module can_master_model (
    input wire logic clk_sys, // System clock
    input wire logic go, // Rising edge sends one frame
    input wire logic [15:0] bit_len, // Cycles per bit
    output logic can_rx // Bus level, recessive high
);
    int i;
    // One frame of alternating bits, so the shortest pulse is one bit long
    initial begin
        can_rx = 1'b1;
        forever begin
            @(posedge go);
            for (i = 0; i < 20; i++) begin
                @(negedge clk_sys);
                can_rx = i[0];
                repeat (bit_len - 16'd1) @(negedge clk_sys);
            end
            can_rx = 1'b1; // Recessive idle closes the frame
        end
    end
endmodule

// ===== tb/node_cfg_tb_top.sv
// Self-checking testbench for the node configuration block
`timescale 1ns/1ps
module node_cfg_tb_top;
    import node_cfg_pkg::*;
    logic clk_sys = 1'b0, rst = 1'b1, nmt_reset = 1'b0, od_wr = 1'b0, od_rd = 1'b0;
    logic preset_load = 1'b0, nvm_done = 1'b0, go = 1'b0, can_rx, led_red, led_green;
    logic [15:0] od_index = 16'h0, event_timer_ms = 16'h1234, single_raw = 16'h8000;
    logic [15:0] bit_len = 16'd300;
    logic [7:0] od_sub = 8'h0, node_id, rate_active;
    logic [63:0] od_wdata = 64'h0, od_rdata;
    logic [30:0] turns_raw = 31'h3;
    logic [31:0] steps_per_rev = 32'h100, preset_value = 32'h1000;
    logic od_ack, od_abort, nvm_save, dev_reset, term_en, listen_only, bootup_send, preop;
    int err_count = 0, tests_run = 0, c;
    always #4 clk_sys = ~clk_sys; // 125 MHz
    node_cfg DUT (.clk_sys, .rst, .nmt_reset, .can_rx, .od_index, .od_sub, .od_wr, .od_rd,
        .od_wdata, .od_rdata, .od_ack, .od_abort, .event_timer_ms, .single_raw, .turns_raw,
        .steps_per_rev, .preset_value, .preset_load, .nvm_done, .nvm_save, .dev_reset, .node_id,
        .rate_active, .term_en, .listen_only, .bootup_send, .preop, .led_red, .led_green);
    can_master_model u_master (.clk_sys, .go, .bit_len, .can_rx);
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [65:0] g, input logic [65:0] e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // One access; returns in the cycle where the answer stands
    task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
                       input logic [63:0] d, input logic [63:0] e, input logic a);
        @(negedge clk_sys);
        od_wr = w;
        od_rd = !w;
        od_index = i;
        od_sub = s;
        od_wdata = d;
        @(negedge clk_sys);
        od_wr = 1'b0;
        od_rd = 1'b0;
        chk({od_ack, od_abort, od_rdata}, {1'b1, a, e});
    endtask
    task automatic wait_boot;
        int n;
        for (n = 0; n < 12000 && bootup_send !== 1'b1; n++) @(negedge clk_sys);
        chk(66'(bootup_send), 66'h1);
        @(negedge clk_sys);
        chk(66'({listen_only, preop, led_red, led_green}), 66'h4);
    endtask
    task final_report;
        $display("mismatches %0d, checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Watchdog: the tests need well under 40000 cycles
    initial begin
        #400000;
        err_count++;
        final_report();
    end
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(negedge clk_sys);
        rst = 1'b0;
        chk(66'({node_id, rate_active, term_en, listen_only, preop}), 66'h1001a);
        acc(1'b0, IDX_NODE_BASE, SUB_COUNT, 64'h0, 64'h1f, 1'b0);
        acc(1'b0, IDX_AUTORATE, SUB_COUNT, 64'h0, 64'h2, 1'b0);
        acc(1'b0, IDX_AUTORATE, SUB_ENABLE, 64'h0, 64'h1, 1'b0);
        acc(1'b0, IDX_AUTORATE, SUB_TIMEOUT, 64'h0, 64'h2bf20, 1'b0);
        acc(1'b0, IDX_CYCLIC_PERIOD, SUB_COUNT, 64'h0, 64'h1234, 1'b0);
        acc(1'b1, IDX_CYCLIC_PERIOD, SUB_COUNT, 64'h5, 64'h0, 1'b1);
        // Off-table bit time first: must be ignored, still listening
        go = 1'b1;
        repeat (10000) @(negedge clk_sys);
        go = 1'b0;
        chk(66'({listen_only, bootup_send, led_red, led_green}), 66'h9);
        bit_len = 16'd125;
        @(negedge clk_sys);
        go = 1'b1;
        wait_boot();
        acc(1'b0, IDX_BIT_RATE, SUB_COUNT, 64'h0, 64'h7, 1'b0);
        for (c = 0; c < 8; c++) begin
            acc(1'b1, IDX_BIT_RATE, SUB_COUNT, 64'(c), 64'h0, 1'b0);
            @(negedge clk_sys);
            chk(66'(rate_active), 66'(c));
        end
        acc(1'b1, IDX_BIT_RATE, SUB_COUNT, 64'h8, 64'h0, 1'b1);
        acc(1'b1, IDX_NODE_BASE, SUB_COUNT, 64'h0, 64'h0, 1'b0);
        @(negedge clk_sys);
        chk(66'(node_id), 66'h1);
        acc(1'b1, IDX_TERM, SUB_COUNT, 64'h1, 64'h0, 1'b0);
        @(negedge clk_sys);
        chk(66'(term_en), 66'h1);
        acc(1'b0, IDX_WIDE_POS, SUB_COUNT, 64'h0, 64'h380, 1'b0);
        acc(1'b1, IDX_WIDE_POS, SUB_COUNT, 64'h1, 64'h0, 1'b1);
        preset_load = 1'b1;
        @(negedge clk_sys);
        preset_load = 1'b0;
        repeat (2) @(negedge clk_sys);
        acc(1'b0, IDX_WIDE_POS, SUB_COUNT, 64'h0, 64'h1000, 1'b0);
        nmt_reset = 1'b1;
        @(negedge clk_sys);
        nmt_reset = 1'b0;
        @(negedge clk_sys);
        chk(66'({listen_only, preop}), 66'h2);
        acc(1'b1, IDX_AUTORATE, SUB_ENABLE, 64'h2, 64'h0, 1'b1);
        acc(1'b1, IDX_AUTORATE, SUB_ENABLE, 64'h0, 64'h0, 1'b0);
        wait_boot();
        acc(1'b1, IDX_SAVE_RESET, SUB_COUNT, 64'h1234, 64'h0, 1'b0);
        chk(66'(nvm_save), 66'h0);
        acc(1'b1, IDX_SAVE_RESET, SUB_COUNT, 64'h55aaaa55, 64'h0, 1'b0);
        chk(66'(nvm_save), 66'h1);
        nvm_done = 1'b1;
        @(negedge clk_sys);
        nvm_done = 1'b0;
        chk(66'(dev_reset), 66'h1);
        final_report();
    end
endmodule
